//--- hw/err_stat_pkg.sv
// Constants, field layout and carrier types for the unit error status bank.
// Assumes one clock (mclk) and a plain strobe register port on the host side.
//
// How it works
// - Summary bit 0 is 1 exactly while any error (memory, setting, model data or model mismatch) shows in the detailed device error word.
// - Summary bit 1 is 1 exactly while any fault shows in the configuration error word.
// - Summary bit 3 is 1 while an external RAM error during operation exists, else 0.
// - Summary bit 4 is 1 while any programless error bit is 1, with no other summary bit set by it.
// - Summary bit 6 is 1 while the programless link has an error, else 0.
// - Detail word bits 4, 6, 9 and 12 report memory, setting, model data and model mismatch errors.
// - Config word bit 8 flags a unit attached left of the head unit and feeds summary bit 1.
// - The summary word reads at item 0000, apart from the detail word at item 0001.
`default_nettype none

package err_stat_pkg;

    localparam int DW = 16;
    localparam int AW = 8;

    // Register items
    localparam logic [AW-1:0] ADDR_SUMM = 8'h00;
    localparam logic [AW-1:0] ADDR_DETAIL = 8'h01;
    localparam logic [AW-1:0] ADDR_CFG = 8'h02;
    localparam logic [AW-1:0] ADDR_PL = 8'h03;
    localparam logic [AW-1:0] ADDR_ISTAT = 8'h10;
    localparam logic [AW-1:0] ADDR_ICLR = 8'h11;
    localparam logic [AW-1:0] ADDR_IEN = 8'h12;

    // Summary word fields
    localparam int SUM_DEV = 0;
    localparam int SUM_CFG = 1;
    localparam int SUM_RAM = 3;
    localparam int SUM_PL = 4;
    localparam int SUM_LINK = 6;

    // Detail word fields
    localparam int DET_NVM = 4;
    localparam int DET_SET = 6;
    localparam int DET_MDATA = 9;
    localparam int DET_MMIS = 12;

    // Configuration word field
    localparam int CFG_ARR = 8;

    // Used-bit masks
    localparam logic [DW-1:0] SUMM_USED = 16'h005B;
    localparam logic [DW-1:0] DET_USED = 16'h1250;
    localparam logic [DW-1:0] CFG_USED = 16'h0100;

    // Reset values
    localparam logic [DW-1:0] WORD_RST = 16'h0000;
    localparam logic [DW-1:0] IEN_RST = 16'h0000;

    localparam int SYNC_STAGES = 2;
    localparam int PL_BITS_DEF = 8;

    typedef struct packed {
        logic nvm;
        logic setting;
        logic model_data;
        logic model_mis;
        logic left_unit;
        logic ext_ram;
        logic link;
    } err_src_s;

    localparam int SRC_W = $bits(err_src_s);

    typedef struct packed {
        logic rd;
        logic wr;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } bus_req_s;

endpackage : err_stat_pkg

`default_nettype wire

//--- hw/err_sync.sv
// Two-stage synchroniser for a vector of independent level signals.
// Assumes each bit is a slow level; multi-bit coherence is not kept.
`default_nettype none

module err_sync
    import err_stat_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_ff;
            logic hold_ff;
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_ff <= 1'b0;
                    hold_ff <= 1'b0;
                end else begin
                    meta_ff <= async_in[i];
                    hold_ff <= meta_ff;
                end
            end
            assign sync_out[i] = hold_ff;
        end
    endgenerate

endmodule : err_sync

`default_nettype wire

//--- hw/unit_error_status_words.sv
// Read-only error status bank of the communication head unit: summary,
// detail and configuration words, plus sticky interrupt status on the summary.
// Assumes error sources are asynchronous levels and the host uses one-cycle strobes.
//
// The strobed register port was left to the implementer.
`default_nettype none

module unit_error_status_words
    import err_stat_pkg::*;
#(
    parameter int PL_BITS = PL_BITS_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Error sources
    input wire err_src_s err_src,
    input wire logic [PL_BITS-1:0] pl_err,
    // Register port
    input wire bus_req_s bus_req,
    output logic [DW-1:0] rdata,
    // Interrupt
    output logic irq
);

    localparam int SW = SRC_W + PL_BITS;

    // Synchronised sources
    logic [SW-1:0] raw_in;
    logic [SW-1:0] syn;
    err_src_s src_s;
    logic [PL_BITS-1:0] pl_s;

    assign raw_in = {err_src, pl_err};
    assign src_s = syn[SW-1:PL_BITS];
    assign pl_s = syn[PL_BITS-1:0];

    err_sync #(
        .W(SW)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(raw_in),
        .sync_out(syn)
    );

    // Status words
    logic [DW-1:0] detail_ff;
    logic [DW-1:0] cfg_ff;
    logic [DW-1:0] summ_ff;
    logic [DW-1:0] pl_ff;
    logic [DW-1:0] nxt_detail;
    logic [DW-1:0] nxt_cfg;
    logic [DW-1:0] nxt_summ;
    logic [DW-1:0] nxt_pl;

    always_comb begin
        nxt_detail = WORD_RST;
        nxt_detail[DET_NVM] = src_s.nvm;
        nxt_detail[DET_SET] = src_s.setting;
        nxt_detail[DET_MDATA] = src_s.model_data;
        nxt_detail[DET_MMIS] = src_s.model_mis;
    end

    always_comb begin
        nxt_cfg = WORD_RST;
        nxt_cfg[CFG_ARR] = src_s.left_unit;
    end

    // Programless error bits are mirrored so the host can see which one fired
    always_comb begin
        nxt_pl = WORD_RST;
        nxt_pl[PL_BITS-1:0] = pl_s;
    end

    // Summary is built from the same-cycle detail and config values so the
    // words never disagree when read together.
    always_comb begin
        nxt_summ = WORD_RST;
        nxt_summ[SUM_DEV] = |(nxt_detail & DET_USED);
        nxt_summ[SUM_CFG] = |(nxt_cfg & CFG_USED);
        nxt_summ[SUM_RAM] = src_s.ext_ram;
        nxt_summ[SUM_PL] = |pl_s;
        nxt_summ[SUM_LINK] = src_s.link;
    end

    // Host writes never reach these flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            detail_ff <= WORD_RST;
            cfg_ff <= WORD_RST;
            summ_ff <= WORD_RST;
            pl_ff <= WORD_RST;
        end else begin
            detail_ff <= nxt_detail;
            cfg_ff <= nxt_cfg;
            summ_ff <= nxt_summ;
            pl_ff <= nxt_pl;
        end
    end

    // Decode
    wire hit_summ = bus_req.addr == ADDR_SUMM;
    wire hit_detail = bus_req.addr == ADDR_DETAIL;
    wire hit_cfg = bus_req.addr == ADDR_CFG;
    wire hit_pl = bus_req.addr == ADDR_PL;
    wire hit_istat = bus_req.addr == ADDR_ISTAT;
    wire hit_iclr = bus_req.addr == ADDR_ICLR;
    wire hit_ien = bus_req.addr == ADDR_IEN;
    wire wr_iclr = bus_req.wr && hit_iclr;
    wire wr_ien = bus_req.wr && hit_ien;

    // Interrupt bank: events are rising edges of summary bits
    logic [DW-1:0] ist_ff;
    logic [DW-1:0] ien_ff;
    logic irq_ff;
    logic [DW-1:0] rise;
    logic [DW-1:0] clr_mask;
    logic [DW-1:0] nxt_ist;
    logic [DW-1:0] nxt_ien;
    logic nxt_irq;

    assign rise = nxt_summ & ~summ_ff;
    assign clr_mask = wr_iclr ? bus_req.wdata : WORD_RST;
    // A new event in the clear cycle survives the clear
    assign nxt_ist = ((ist_ff & ~clr_mask) | rise) & SUMM_USED;
    assign nxt_ien = wr_ien ? (bus_req.wdata & SUMM_USED) : ien_ff;
    assign nxt_irq = |(ist_ff & ien_ff);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ist_ff <= WORD_RST;
            ien_ff <= IEN_RST;
            irq_ff <= 1'b0;
        end else begin
            ist_ff <= nxt_ist;
            ien_ff <= nxt_ien;
            irq_ff <= nxt_irq;
        end
    end

    // Read path: data stands only in the cycle after the strobe
    logic [DW-1:0] rdata_ff;
    logic [DW-1:0] rd_sel;
    logic [DW-1:0] nxt_rdata;

    assign rd_sel = hit_summ ? summ_ff :
                    hit_detail ? detail_ff :
                    hit_cfg ? cfg_ff :
                    hit_pl ? pl_ff :
                    hit_istat ? ist_ff :
                    hit_ien ? ien_ff :
                    WORD_RST;
    assign nxt_rdata = bus_req.rd ? rd_sel : WORD_RST;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= WORD_RST;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata = rdata_ff;
    assign irq = irq_ff;

    // Checks
    a_dev_err_sum: assert property (
        @(posedge mclk) disable iff (!rst_n)
        summ_ff[SUM_DEV] == |(detail_ff & DET_USED)
    ) else $error("summary device error bit disagrees with detail word");

    a_cfg_err_sum: assert property (
        @(posedge mclk) disable iff (!rst_n)
        summ_ff[SUM_CFG] == cfg_ff[CFG_ARR]
    ) else $error("summary config error bit disagrees with config word");

    a_ram_err_bit: assert property (
        @(posedge mclk) disable iff (!rst_n)
        src_s.ext_ram |=> summ_ff[SUM_RAM]
    ) else $error("external RAM error not shown in summary");

    a_ram_clear_bit: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !src_s.ext_ram |=> !summ_ff[SUM_RAM]
    ) else $error("summary RAM bit set without error");

    a_pl_err_sum: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ##1 summ_ff[SUM_PL] == (|$past(pl_s))
    ) else $error("summary programless bit wrong");

    a_pl_no_side: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (|pl_s && !src_s.link) |=> !summ_ff[SUM_LINK]
    ) else $error("programless bits set another status");

    a_link_err_bit: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ##1 summ_ff[SUM_LINK] == $past(src_s.link)
    ) else $error("summary link bit wrong");

    a_detail_map_bits: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ##1 detail_ff == {3'h0, $past(src_s.model_mis), 2'h0, $past(src_s.model_data),
                          2'h0, $past(src_s.setting), 1'b0, $past(src_s.nvm), 4'h0}
    ) else $error("detail word layout wrong");

    a_unused_zero: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ((summ_ff & ~SUMM_USED) == WORD_RST) && ((detail_ff & ~DET_USED) == WORD_RST)
    ) else $error("unused status bit is set");

    a_cfg_unused_zero: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (cfg_ff & ~CFG_USED) == WORD_RST
    ) else $error("unused config bit is set");

    a_write_ignored: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (bus_req.wr && (hit_summ || hit_detail)) |=> summ_ff == $past(nxt_summ)
    ) else $error("host write disturbed the summary word");

    a_arrange_flag: assert property (
        @(posedge mclk) disable iff (!rst_n)
        src_s.left_unit |=> cfg_ff[CFG_ARR] && summ_ff[SUM_CFG]
    ) else $error("illegal arrangement not flagged");

    a_arrange_clear: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !src_s.left_unit |=> !cfg_ff[CFG_ARR]
    ) else $error("arrangement flag set without a left unit");

    a_pl_mirror: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ##1 pl_ff[PL_BITS-1:0] == $past(pl_s)
    ) else $error("programless mirror does not follow the error bits");

    a_read_summary: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (bus_req.rd && hit_summ) |=> rdata_ff == $past(summ_ff)
    ) else $error("summary item read returned wrong data");

    a_read_detail: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (bus_req.rd && hit_detail) |=> rdata_ff == $past(detail_ff)
    ) else $error("detail item read returned wrong data");

    // Remaining items and the idle bus
    a_read_config: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (bus_req.rd && hit_cfg) |=> rdata_ff == $past(cfg_ff)
    ) else $error("config item read returned wrong data");

    a_read_mirror: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (bus_req.rd && hit_pl) |=> rdata_ff == $past(pl_ff)
    ) else $error("mirror item read returned wrong data");

    a_read_istat: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (bus_req.rd && hit_istat) |=> rdata_ff == $past(ist_ff)
    ) else $error("interrupt status read returned wrong data");

    a_read_ien: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (bus_req.rd && hit_ien) |=> rdata_ff == $past(ien_ff)
    ) else $error("interrupt enable read returned wrong data");

    a_read_unmapped: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (bus_req.rd && !(hit_summ || hit_detail || hit_cfg || hit_pl || hit_istat || hit_ien))
            |=> rdata_ff == WORD_RST
    ) else $error("unmapped item read returned data");

    // Stale read data would let software take an old word for a fresh one
    a_rdata_idle_zero: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !bus_req.rd |=> rdata_ff == WORD_RST
    ) else $error("read data not zero outside a read");

    // Interrupt bank
    a_ien_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr_ien |=> ien_ff == ($past(bus_req.wdata) & SUMM_USED)
    ) else $error("interrupt enable write not taken");

    a_ien_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !wr_ien |=> $stable(ien_ff)
    ) else $error("interrupt enable changed without a write");

    a_clear_bits: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr_iclr |=> (ist_ff & $past(bus_req.wdata) & ~$past(rise)) == WORD_RST
    ) else $error("status bit survived its clear");

    a_ist_sticky: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !wr_iclr |=> (ist_ff & $past(ist_ff)) == $past(ist_ff)
    ) else $error("status bit lost without a clear");

    a_ist_set_rise: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ##1 (ist_ff & $past(rise) & SUMM_USED) == ($past(rise) & SUMM_USED)
    ) else $error("summary rise did not set interrupt status");

    a_ist_no_spurious: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ##1 (ist_ff & ~$past(ist_ff) & ~$past(rise)) == WORD_RST
    ) else $error("interrupt status set without an event");

    a_irq_level: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ##1 irq_ff == (|($past(ist_ff) & $past(ien_ff)))
    ) else $error("interrupt level does not follow enabled status");

    a_set_beats_clr: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (rise[SUM_RAM] && wr_iclr) |=> ist_ff[SUM_RAM]
    ) else $error("event lost to a clear in the same cycle");

    c_read_summary: cover property (
        @(posedge mclk) disable iff (!rst_n)
        bus_req.rd && hit_summ && summ_ff != WORD_RST
    );

    c_irq_raised: cover property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(irq_ff)
    );

    c_clear_irq: cover property (
        @(posedge mclk) disable iff (!rst_n)
        irq_ff ##1 wr_iclr ##2 !irq_ff
    );

    c_arrange_err: cover property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(summ_ff[SUM_CFG])
    );

    c_set_beats_clr: cover property (
        @(posedge mclk) disable iff (!rst_n)
        rise[SUM_RAM] && wr_iclr
    );

endmodule : unit_error_status_words

`default_nettype wire

//--- test/host_model.sv
// Host model: reads and writes the status bank over the strobe register port.
// Assumes the bank answers a read in the cycle after the strobe, never waits.
`default_nettype none

module host_model
    import err_stat_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Register port
    output var bus_req_s bus_req,
    input wire logic [DW-1:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial bus_req = '0;

    // Released address and data are inverted so stale values never look valid
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        bus_req <= '{1'b0, 1'b1, a, d};
        @(posedge mclk);
        bus_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge mclk);
        bus_req <= '{1'b1, 1'b0, a, 16'h0000};
        @(posedge mclk);
        bus_req <= '{1'b0, 1'b0, ~a, 16'hFFFF};
        #1;
        d = rdata;
    endtask : rd
endmodule : host_model

`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the unit error status bank.
// Assumes the host model drives the register port; sources are driven here.
`default_nettype none

module testbench
    import err_stat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk;
    logic rst_n;
    err_src_s err_src;
    logic [PL_BITS_DEF-1:0] pl_err;
    bus_req_s bus_req;
    logic [DW-1:0] rdata;
    logic irq;
    int n_fail;
    int cmp_count;

    unit_error_status_words #(.PL_BITS(PL_BITS_DEF)) dut (
        .mclk(mclk), .rst_n(rst_n), .err_src(err_src), .pl_err(pl_err),
        .bus_req(bus_req), .rdata(rdata), .irq(irq));

    host_model host (.mclk(mclk), .bus_req(bus_req), .rdata(rdata));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [DW-1:0] got, input logic [DW-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        logic [DW-1:0] v;
        host.rd(a, v);
        chk($sformatf("item %h", a), v, exp);
    endtask : rdc

    // Sources take 3 edges to reach the words; one spare edge
    task automatic drive(input logic [6:0] s, input logic [PL_BITS_DEF-1:0] p);
        @(posedge mclk);
        err_src <= err_src_s'(s);
        pl_err <= p;
        repeat (4) @(posedge mclk);
    endtask : drive

    task automatic t_reset();
        rdc(ADDR_SUMM, 16'h0000);
        rdc(ADDR_DETAIL, 16'h0000);
        rdc(ADDR_CFG, 16'h0000);
        chk("irq", {15'h0000, irq}, 16'h0000);
    endtask : t_reset

    task automatic t_detail();
        int pos[4] = '{DET_NVM, DET_SET, DET_MDATA, DET_MMIS};
        for (int i = 0; i < 4; i++) begin
            drive(7'h40 >> i, '0);
            rdc(ADDR_DETAIL, 16'h0001 << pos[i]);
            rdc(ADDR_SUMM, 16'h0001);
        end
        drive(7'h00, '0);
        rdc(ADDR_SUMM, 16'h0000);
    endtask : t_detail

    task automatic t_other();
        drive(7'h04, '0);
        rdc(ADDR_CFG, 16'h0100);
        rdc(ADDR_SUMM, 16'h0002);
        drive(7'h02, '0);
        rdc(ADDR_SUMM, 16'h0008);
        drive(7'h01, '0);
        rdc(ADDR_SUMM, 16'h0040);
        drive(7'h00, 8'h80);
        rdc(ADDR_SUMM, 16'h0010);
        rdc(ADDR_PL, 16'h0080);
        drive(7'h00, 8'h01);
        rdc(ADDR_SUMM, 16'h0010);
        drive(7'h00, '0);
        rdc(ADDR_SUMM, 16'h0000);
    endtask : t_other

    // Writes to read-only and unmapped items must change nothing
    task automatic t_write();
        host.wr(ADDR_SUMM, 16'hFFFF);
        host.wr(ADDR_DETAIL, 16'hFFFF);
        host.wr(8'h55, 16'hFFFF);
        rdc(ADDR_SUMM, 16'h0000);
        rdc(ADDR_DETAIL, 16'h0000);
        rdc(8'h55, 16'h0000);
    endtask : t_write

    task automatic t_irq();
        host.wr(ADDR_IEN, 16'hFFFF);
        rdc(ADDR_IEN, 16'h005B);
        host.wr(ADDR_IEN, 16'h0008);
        host.wr(ADDR_ICLR, 16'hFFFF);
        rdc(ADDR_ISTAT, 16'h0000);
        drive(7'h02, '0);
        @(posedge mclk);
        chk("irq", {15'h0000, irq}, 16'h0001);
        drive(7'h01, '0);
        rdc(ADDR_ISTAT, 16'h0048);
        chk("irq", {15'h0000, irq}, 16'h0001);
        host.wr(ADDR_ICLR, 16'h0008);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq", {15'h0000, irq}, 16'h0000);
        rdc(ADDR_ISTAT, 16'h0040);
        drive(7'h00, '0);
        // Clear sampled at the very edge that takes the RAM event: the event must stay
        @(posedge mclk);
        err_src <= err_src_s'(7'h02);
        @(posedge mclk);
        host.wr(ADDR_ICLR, 16'h0048);
        repeat (2) @(posedge mclk);
        rdc(ADDR_ISTAT, 16'h0008);
        chk("irq", {15'h0000, irq}, 16'h0001);
        // Reset in mid-run with the RAM error still present
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("irq", {15'h0000, irq}, 16'h0000);
        chk("rdata", rdata, 16'h0000);
        rst_n <= 1'b1;
        rdc(ADDR_IEN, 16'h0000);
        drive(7'h02, '0);
        rdc(ADDR_SUMM, 16'h0008);
        rdc(ADDR_ISTAT, 16'h0008);
        chk("irq", {15'h0000, irq}, 16'h0000);
        drive(7'h00, '0);
    endtask : t_irq

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        #20000;
        n_fail++;
        results();
    end

    initial begin
        n_fail = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        err_src = '0;
        pl_err = '0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_detail();
        t_other();
        t_write();
        t_irq();
        results();
    end
endmodule : testbench

`default_nettype wire
